// ### common/pou_pkg.sv
// constants for the pattern output data path
// assumes 32-bit apb data, byte-wide registers in the low bits of each word
package pou_pkg;
   // printed offsets are not multiples of four: these are indices, byte address is 4x
   localparam logic [19:0] idx_high_direction = 20'hee00a;
   localparam logic [19:0] idx_low_direction = 20'hee009;
   localparam logic [19:0] idx_low_output = 20'hfffd9;
   localparam logic [19:0] idx_high_output = 20'hfffda;
   localparam logic [19:0] idx_trigger_select = 20'hfffa1;
   localparam logic [19:0] idx_high_enable = 20'hfffa2;
   localparam logic [19:0] idx_low_enable = 20'hfffa3;
   localparam logic [19:0] idx_next_high = 20'hfffa4;
   localparam logic [19:0] idx_next_low = 20'hfffa5;
   localparam logic [19:0] idx_next_group2 = 20'hfffa6;
   localparam logic [19:0] idx_next_group0 = 20'hfffa7;
   localparam int addr_w = 22;
   localparam logic [7:0] rst_zero = 8'h00;
   localparam logic [7:0] rst_trigger = 8'hff;
   localparam logic [3:0] reserved_nib = 4'hf;
   localparam logic [1:0] sel_ch0 = 2'h0;
   localparam logic [1:0] sel_ch1 = 2'h1;
   typedef struct packed {
      logic [7:0] low_direction;
      logic [7:0] high_direction;
      logic [7:0] low_output;
      logic [7:0] high_output;
      logic [7:0] low_enable;
      logic [7:0] high_enable;
      logic [7:0] next_low;
      logic [7:0] next_high;
      logic [7:0] trigger_select;
      logic [31:0] rdata;
   } pou_state_type;
endpackage

// ### logic/pou_data_path.sv
// pattern output data path: sixteen pattern outputs over two byte ports
// assumes an apb master on core_clk and compare-match pulses from same clock
// Operation
// (R1) write-only low port direction register
// (R2) software sets direction for pattern pins
// (R3) outputs 7..0 low port, 15..8 high
// (R4) low port data, enabled bits read-only
// (R5) high port data, enabled bits read-only
// (R6) low group match copies next data
// (R7) high group match copies next data
// (R8) next data cleared on reset, standby
// (R9) shared trigger: low next byte at a5
// (R10) shared trigger: a7 reserved, reads ones
// (R11) split trigger: group0 nibble at a7
// (R12) shared trigger: high byte a4, a6 reserved
// (R13) split trigger: group2 nibble at a6
// (R14) low enable bit gates each copy
// (R15) low enable register rw, cleared reset
// (R16) high enable bit gates each copy
// (R17) two-bit select per group, reset ch2
// (R18) copy in the cycle of the match
`timescale 1ns/100ps
`default_nettype none
module pou_data_path
(
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic hw_standby,
   input wire logic [2:0] compare_match,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [pou_pkg::addr_w-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [7:0] low_pin_in,
   input wire logic [7:0] high_pin_in,
   output logic [7:0] low_pin_out,
   output logic [7:0] low_pin_oe_n,
   output logic [7:0] high_pin_out,
   output logic [7:0] high_pin_oe_n
);
   import pou_pkg::*;

   // register map; index times four gives the byte address
   // low_port_direction ee009: write only, reads as zero
   // high_port_direction ee00a: write only, reads as zero
   // low_port_output fffd9: pins 7..0, enabled bits locked
   // high_port_output fffda: pins 15..8, enabled bits locked
   // trigger_select_reg fffa1: two bits per group, reset ff
   // high_transfer_enable fffa2: one bit per pin 15..8
   // low_transfer_enable fffa3: one bit per pin 7..0
   // next_pattern_high fffa4: whole byte, or group 3 when split
   // next_pattern_low fffa5: whole byte, or group 1 when split
   // next_pattern_group2_split fffa6: group 2 nibble when split
   // next_pattern_group0_split fffa7: group 0 nibble when split
   // unused nibbles and unused split bytes read as ones
   // output mode register not built: its index gets an error

   // behaviour that software must know
   // a trigger change moves the next-data layout at once,
   //    so rewrite next data after changing the trigger
   // a port write and a match in one cycle: the match wins
   // shared or split is a bit-for-bit test of the two fields,
   //    so codes 10 and 11 count as different triggers
   // enabled bits of a group all move on the same edge
   // enable bit clear: that pin keeps its value on a match
   // direction bit must be one for the pattern to leave the pin
   // hardware standby clears like reset and beats the bus
   // software standby needs nothing: the clock stops and
   //    every register keeps its value
   // bytes sit in pwdata[7:0]; upper bits written are dropped
   // no wait states: pready is held high
   // read data captured in the setup cycle, stands through
   //    the access phase, zero otherwise
   // transfer sources: ch0, ch1, ch2 match pulses, one cycle each
   // select codes: 00 ch0, 01 ch1, 10 and 11 ch2
   // reset values all zero except the select, which picks ch2
   //    so after reset both halves start in the shared layout
   // port read of an input pin lags the pad by three to four clocks
   // port read of an output pin gives the port data, not the pad

   // state and its next value
   pou_state_type s_reg;
   pou_state_type s_next;
   // bus decode
   logic [19:0] idx;
   logic wr;
   logic rd;
   logic hit;
   // trigger decode
   logic [3:0] fire;
   logic [1:0] low_same;
   logic [1:0] high_same;
   // pin input synchronisers and filtered levels
   logic [7:0] low_sync_a_reg;
   logic [7:0] low_sync_b_reg;
   logic [7:0] low_sync_c_reg;
   logic [7:0] high_sync_a_reg;
   logic [7:0] high_sync_b_reg;
   logic [7:0] high_sync_c_reg;
   logic [7:0] low_in_reg;
   logic [7:0] high_in_reg;

   // register index from byte address, word aligned
   assign idx = paddr[21:2];
   // writes act at the access edge
   assign wr = psel && penable && pwrite;
   // reads captured at the setup edge so data stands at the access edge
   assign rd = psel && !penable && !pwrite;
   assign pready = 1'b1;
   assign prdata = s_reg.rdata;
   // mapped indices; anything else answers with an error
   assign hit = (idx == idx_low_direction) ||
                (idx == idx_high_direction) ||
                (idx == idx_low_output) ||
                (idx == idx_high_output) ||
                (idx == idx_trigger_select) ||
                (idx == idx_high_enable) ||
                (idx == idx_low_enable) ||
                (idx == idx_next_high) ||
                (idx == idx_next_low) ||
                (idx == idx_next_group2) ||
                (idx == idx_next_group0);
   assign pslverr = psel && penable && !hit;

   // per-group trigger decode; codes 10 and 11 both pick channel 2
   // no pulse stretching: a match held high copies again each cycle
   // groups are independent; one pulse may fire all four
   genvar g;
   generate
      for (g = 0; g < 4; g = g + 1)
      begin : grp
         logic [1:0] sel;
         assign sel = s_reg.trigger_select[2*g+1:2*g];
         assign fire[g] = (sel == sel_ch0) ? compare_match[0] :
                          (sel == sel_ch1) ? compare_match[1] :
                          compare_match[2]; // see (R17)
      end
   endgenerate

   // shared trigger decides the next-data address layout
   // bit 1 of each flag is spare and stays zero
   assign low_same = {1'b0, s_reg.trigger_select[3:2] == s_reg.trigger_select[1:0]};
   assign high_same = {1'b0, s_reg.trigger_select[7:6] == s_reg.trigger_select[5:4]};

   // pins: driven low-active enable from direction bits
   // straight from flops, so the pad never sees a glitch
   // reset leaves every pin released
   assign low_pin_out = s_reg.low_output; // see (R3)
   assign high_pin_out = s_reg.high_output; // see (R3)
   assign low_pin_oe_n = ~s_reg.low_direction; // see (R2)
   assign high_pin_oe_n = ~s_reg.high_direction; // see (R2)

   // pin reads pass three flops; value changes once last two agree
   // first flop may go metastable; only the second reads it
   // agreement of two flops also drops a one-cycle glitch
   // no reset on the chain: it flushes itself in three clocks
   // filtered level only feeds port reads of input pins
   always_ff @(posedge core_clk)
   begin
      low_sync_a_reg <= low_pin_in;
      low_sync_b_reg <= low_sync_a_reg;
      low_sync_c_reg <= low_sync_b_reg;
      high_sync_a_reg <= high_pin_in;
      high_sync_b_reg <= high_sync_a_reg;
      high_sync_c_reg <= high_sync_b_reg;
      if (!nrst)
      begin
         low_in_reg <= rst_zero;
         high_in_reg <= rst_zero;
      end
      else
      begin
         low_in_reg <= (low_sync_b_reg & low_sync_c_reg) |
                       (low_in_reg & (low_sync_b_reg | low_sync_c_reg));
         high_in_reg <= (high_sync_b_reg & high_sync_c_reg) |
                        (high_in_reg & (high_sync_b_reg | high_sync_c_reg));
      end
   end

   // register writes, transfers and read capture, all from the old state
   always_comb
   begin
      logic [7:0] wb;
      logic [7:0] lo_mask;
      logic [7:0] hi_mask;
      wb = pwdata[7:0];
      s_next = s_reg;
      // transfer masks: group fired and bit enabled
      lo_mask = {{4{fire[1]}}, {4{fire[0]}}} & s_reg.low_enable; // see (R14)
      hi_mask = {{4{fire[3]}}, {4{fire[2]}}} & s_reg.high_enable; // see (R16)
      // software writes first; enabled bits ignore them
      if (wr)
      begin
         case (idx)
            // direction: written only, never read back
            idx_low_direction:
            begin
               s_next.low_direction = wb; // see (R1)
            end
            idx_high_direction:
            begin
               s_next.high_direction = wb;
            end
            // port data: bits owned by the transfer keep their value
            idx_low_output:
            begin
               s_next.low_output = (wb & ~s_reg.low_enable) |
                                   (s_reg.low_output & s_reg.low_enable); // see (R4)
            end
            idx_high_output:
            begin
               s_next.high_output = (wb & ~s_reg.high_enable) |
                                    (s_reg.high_output & s_reg.high_enable); // see (R5)
            end
            // new trigger moves the next-data layout from the next cycle
            idx_trigger_select:
            begin
               s_next.trigger_select = wb; // see (R17)
            end
            // enables: a bit set hands its pin to the transfer
            idx_high_enable:
            begin
               s_next.high_enable = wb;
            end
            idx_low_enable:
            begin
               s_next.low_enable = wb; // see (R15)
            end
            // high next data: whole byte shared, group 3 only when split
            idx_next_high:
            begin
               if (high_same[0])
               begin
                  s_next.next_high = wb; // see (R12)
               end
               else
               begin
                  s_next.next_high[7:4] = wb[7:4]; // see (R13)
               end
            end
            // low next data: whole byte shared, group 1 only when split
            idx_next_low:
            begin
               if (low_same[0])
               begin
                  s_next.next_low = wb; // see (R9)
               end
               else
               begin
                  s_next.next_low[7:4] = wb[7:4]; // see (R11)
               end
            end
            // split bytes: writes ignored while the groups share a trigger
            idx_next_group2:
            begin
               if (!high_same[0])
               begin
                  s_next.next_high[3:0] = wb[3:0]; // see (R13)
               end
            end
            idx_next_group0:
            begin
               if (!low_same[0])
               begin
                  s_next.next_low[3:0] = wb[3:0]; // see (R10) (R11)
               end
            end
            // unmapped index: nothing changes, error on the bus
            default:
            begin
               s_next.rdata = s_reg.rdata;
            end
         endcase
      end
      // transfer in the match cycle; enabled bits of a group move together
      // applied after the write, so a match beats a port write
      s_next.low_output = (s_next.low_output & ~lo_mask) |
                          (s_reg.next_low & lo_mask); // see (R6) (R18)
      s_next.high_output = (s_next.high_output & ~hi_mask) |
                           (s_reg.next_high & hi_mask); // see (R7) (R18)
      // read data captured in setup; direction is write-only, reads zero
      s_next.rdata = 32'h0000_0000;
      if (rd)
      begin
         case (idx)
            // port read: output pins give port data, inputs the pin
            idx_low_output:
            begin
               s_next.rdata[7:0] = (s_reg.low_output & s_reg.low_direction) |
                                   (low_in_reg & ~s_reg.low_direction);
            end
            idx_high_output:
            begin
               s_next.rdata[7:0] = (s_reg.high_output & s_reg.high_direction) |
                                   (high_in_reg & ~s_reg.high_direction);
            end
            // control registers read back as written
            idx_trigger_select:
            begin
               s_next.rdata[7:0] = s_reg.trigger_select;
            end
            idx_high_enable:
            begin
               s_next.rdata[7:0] = s_reg.high_enable;
            end
            idx_low_enable:
            begin
               s_next.rdata[7:0] = s_reg.low_enable;
            end
            // next data: spare nibble of a split layout reads ones
            idx_next_high:
            begin
               s_next.rdata[7:0] = high_same[0] ? s_reg.next_high :
                                   {s_reg.next_high[7:4], reserved_nib};
            end
            idx_next_low:
            begin
               s_next.rdata[7:0] = low_same[0] ? s_reg.next_low :
                                   {s_reg.next_low[7:4], reserved_nib};
            end
            // split bytes read all ones while the trigger is shared
            idx_next_group2:
            begin
               s_next.rdata[7:0] = high_same[0] ? {reserved_nib, reserved_nib} :
                                   {reserved_nib, s_reg.next_high[3:0]}; // see (R12)
            end
            idx_next_group0:
            begin
               s_next.rdata[7:0] = low_same[0] ? {reserved_nib, reserved_nib} :
                                   {reserved_nib, s_reg.next_low[3:0]}; // see (R10)
            end
            // unmapped and write-only indices read zero
            default:
            begin
               s_next.rdata[7:0] = rst_zero;
            end
         endcase
      end
   end

   // reset and hardware standby clear; software standby needs no action
   // standby is a level: registers stay cleared while it is high
   // a bus write in a standby cycle is lost on purpose
   // select resets to all ones, so both halves start shared
   always_ff @(posedge core_clk)
   begin
      if (!nrst || hw_standby)
      begin
         s_reg.low_direction <= rst_zero;
         s_reg.high_direction <= rst_zero;
         s_reg.low_output <= rst_zero;
         s_reg.high_output <= rst_zero;
         s_reg.low_enable <= rst_zero; // see (R15)
         s_reg.high_enable <= rst_zero;
         s_reg.next_low <= rst_zero; // see (R8)
         s_reg.next_high <= rst_zero; // see (R8)
         s_reg.trigger_select <= rst_trigger; // see (R17)
         s_reg.rdata <= 32'h0000_0000;
      end
      else
      begin
         s_reg <= s_next;
      end
   end
endmodule
`default_nettype wire

// ### tb/pou_far_side.sv
// far side model: timer compare-match source and the shared port pins
// assumes the bench asks for one-cycle pulses on the design clock
`timescale 1ns/100ps
`default_nettype none
module pou_far_side
(
   input wire logic [2:0] fire,
   input wire logic [7:0] low_pin_out,
   input wire logic [7:0] low_pin_oe_n,
   input wire logic [7:0] high_pin_out,
   input wire logic [7:0] high_pin_oe_n,
   output logic [2:0] compare_match,
   output logic [7:0] low_pin_in,
   output logic [7:0] high_pin_in
);
   // match pulses follow the request; same clock, so no sync stage
   assign compare_match = fire;
   // released pins float up on the pull-ups, driven pins show the port data
   assign low_pin_in = (low_pin_out & ~low_pin_oe_n) | low_pin_oe_n;
   assign high_pin_in = (high_pin_out & ~high_pin_oe_n) | high_pin_oe_n;
endmodule
`default_nettype wire

// ### tb/pou_monitor.sv
// checker for the pattern output data path, bound to its ports
// assumes a one-cycle apb access phase and one-cycle match pulses
`timescale 1ns/100ps
`default_nettype none
module pou_monitor
(
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic hw_standby,
   input wire logic [2:0] compare_match,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [pou_pkg::addr_w-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pslverr,
   input wire logic [7:0] low_pin_out,
   input wire logic [7:0] low_pin_oe_n,
   input wire logic [7:0] high_pin_out,
   input wire logic [7:0] high_pin_oe_n
);
   import pou_pkg::*;
   // one completed write to a register index, standby not fighting it
   sequence wr_to(logic [19:0] idx);
      psel && penable && pwrite && !hw_standby && paddr == {idx, 2'b00};
   endsequence
   reset_clears_a: assert property (@(posedge core_clk) disable iff (!nrst) $rose(nrst) |->
      low_pin_out == 8'h00 && high_pin_out == 8'h00 && (low_pin_oe_n & high_pin_oe_n) == 8'hff)
      else $error("outputs not cleared by reset");
   standby_clears_a: assert property (@(posedge core_clk) disable iff (!nrst) hw_standby |=>
      low_pin_out == 8'h00 && high_pin_out == 8'h00 && (low_pin_oe_n & high_pin_oe_n) == 8'hff)
      else $error("outputs not cleared by standby");
   low_dir_write_a: assert property (@(posedge core_clk) disable iff (!nrst)
      wr_to(idx_low_direction) |=> low_pin_oe_n == ~$past(pwdata[7:0]))
      else $error("low direction write not seen on enables");
   high_dir_write_a: assert property (@(posedge core_clk) disable iff (!nrst)
      wr_to(idx_high_direction) |=> high_pin_oe_n == ~$past(pwdata[7:0]))
      else $error("high direction write not seen on enables");
   pins_hold_a: assert property (@(posedge core_clk) disable iff (!nrst)
      !hw_standby && compare_match == 3'h0 && !(psel && penable && pwrite)
      |=> $stable(low_pin_out) && $stable(high_pin_out)) else $error("pins moved without cause");
   oe_hold_a: assert property (@(posedge core_clk) disable iff (!nrst) $changed(low_pin_oe_n)
      |-> $past(psel && penable && pwrite) || $past(hw_standby) || !$past(nrst))
      else $error("low enables moved without a write");
   slverr_phase_a: assert property (@(posedge core_clk) disable iff (!nrst)
      pslverr |-> psel && penable) else $error("error response outside access phase");
   rdata_idle_a: assert property (@(posedge core_clk) disable iff (!nrst)
      prdata != 32'h0 |-> $past(psel && !penable && !pwrite)) else $error("read data without read");
endmodule
bind pou_data_path pou_monitor u_pou_monitor (.*);
`default_nettype wire

// ### tb/testbench.sv
// self-checking bench for the pattern output data path
// assumes the far-side model drives matches and pins, checker bound by itself
`timescale 1ns/100ps
`default_nettype none
module testbench;
   import pou_pkg::*;
   `define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin miscompares++; \
      $display("unexpected %s expected %h seen %h", n, e, g); end end
   typedef struct {logic [19:0] idx; logic [7:0] d; logic [7:0] q;} pou_row_type;
   logic core_clk = 0, nrst = 0, hw_standby = 0, psel = 0, penable = 0, pwrite = 0;
   logic [2:0] fire = 3'h0, compare_match;
   logic [21:0] paddr = 22'h000000;
   logic [31:0] pwdata = 32'h00000000, prdata;
   logic pready, pslverr, err;
   logic [7:0] low_pin_in, high_pin_in, low_pin_out, low_pin_oe_n, high_pin_out, high_pin_oe_n, q;
   int miscompares = 0, n_compared = 0;
   // shared-trigger setup, then split triggers: g3 ch2, g2 ch0, g1 ch1, g0 ch0
   pou_row_type rows[14] = '{'{idx_low_enable, 8'h5a, 8'h5a}, '{idx_next_low, 8'ha5, 8'ha5},
      '{idx_next_group0, 8'h00, 8'hff}, '{idx_next_high, 8'h3c, 8'h3c},
      '{idx_next_group2, 8'h00, 8'hff}, '{idx_low_direction, 8'hff, 8'h00},
      '{idx_high_direction, 8'hff, 8'h00}, '{idx_low_enable, 8'hff, 8'hff},
      '{idx_high_enable, 8'h0f, 8'h0f}, '{idx_trigger_select, 8'h84, 8'h84},
      '{idx_next_low, 8'h30, 8'h3f}, '{idx_next_group0, 8'h0c, 8'hfc},
      '{idx_next_high, 8'h90, 8'h9f}, '{idx_next_group2, 8'h06, 8'hf6}};
   pou_data_path u_pou_data_path (.*);
   pou_far_side u_pou_far_side (.*);
   // 40 MHz clock
   always #12.5 core_clk = ~core_clk;
   task automatic test_done();
      $display("compares %0d mismatches %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // one apb transfer; read data taken at the edge that sees pready
   task automatic xfer(input logic w, input logic [19:0] idx, input logic [7:0] d);
      int n;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {idx, 2'b00};
      pwdata <= {24'h000000, d};
      @(posedge core_clk);
      penable <= 1'b1;
      for (n = 0; n < 20; n++)
      begin
         @(posedge core_clk);
         if (pready === 1'b1)
            break;
      end
      if (n == 20)
      begin
         miscompares++;
         test_done();
      end
      err = pslverr;
      q = prdata[7:0];
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge core_clk);
   endtask
   task automatic rd(input logic [19:0] idx, input logic [7:0] e);
      xfer(1'b0, idx, 8'h00);
      `CHK("read data", e, q)
   endtask
   // match pulse one cycle wide, pins looked at once the copy has landed
   task automatic pulse(input logic [2:0] ch, input logic [7:0] lo, input logic [7:0] hi);
      fire <= ch;
      @(posedge core_clk);
      fire <= 3'h0;
      @(posedge core_clk);
      `CHK("low pins", lo, low_pin_out)
      `CHK("high pins", hi, high_pin_out)
   endtask
   initial
   begin
      repeat (12) @(posedge core_clk);
      nrst <= 1'b1;
      @(posedge core_clk);
      `CHK("enables after reset", 8'hff, low_pin_oe_n & high_pin_oe_n)
      rd(idx_trigger_select, 8'hff);
      foreach (rows[i])
      begin
         xfer(1'b1, rows[i].idx, rows[i].d);
         rd(rows[i].idx, rows[i].q);
      end
      `CHK("enables", 8'h00, low_pin_oe_n | high_pin_oe_n)
      pulse(3'b001, 8'h0c, 8'h06);
      pulse(3'b010, 8'h3c, 8'h06);
      pulse(3'b100, 8'h3c, 8'h06);
      xfer(1'b1, idx_low_enable, 8'h0f);
      xfer(1'b1, idx_low_output, 8'hff);
      xfer(1'b1, idx_high_output, 8'hff);
      pulse(3'b000, 8'hfc, 8'hf6);
      xfer(1'b1, idx_trigger_select, 8'hff);
      xfer(1'b1, idx_next_high, 8'h5a);
      pulse(3'b100, 8'hfc, 8'hfa);
      xfer(1'b0, 20'h00000, 8'h00);
      `CHK("error response", 1'b1, err)
      hw_standby <= 1'b1;
      pulse(3'b000, 8'h00, 8'h00);
      hw_standby <= 1'b0;
      rd(idx_next_low, 8'h00);
      rd(idx_low_enable, 8'h00);
      rd(idx_low_output, 8'hff);
      test_done();
   end
endmodule
`default_nettype wire
